//--- hdl/cgps_top.sv
// Start-up sequencer, power-good outputs and fault latch of a core rail
`timescale 1ns/1ns
module cgps_top
    import cgps_pkg::*;
#(
    parameter int DELAY_CYCLES = DELAY_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic enable_pin,
    input wire logic supply_lockout,
    input wire logic in_window,
    input wire logic at_boot_level,
    input wire logic overvoltage_trip,
    input wire logic over_2v_trip,
    input wire logic cur_limit,
    input wire logic switch_clk,
    input wire logic softstart_done,
    input wire logic sleep_pin,
    input wire logic [CODE_W-1:0] voltage_code,
    input wire logic high_cmd,
    input wire logic low_cmd,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic core_good_oe,
    output logic delayed_good_oe,
    output logic high_side_gate,
    output logic low_side_gate,
    output logic softstart_low_oe,
    output logic softstart_high,
    output logic ref_follow_code,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [PIN_W-1:0] pin_q;
    logic s_en, s_lock, s_win, s_boot, s_o114, s_o2v, s_cl, s_sw;
    logic s_ssd, s_slp, s_hi, s_lo;
    logic [CODE_W-1:0] s_code;

    cgps_sync #(.W(PIN_W)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .d({enable_pin, supply_lockout, in_window, at_boot_level,
            overvoltage_trip, over_2v_trip, cur_limit, switch_clk,
            softstart_done, sleep_pin, voltage_code, high_cmd, low_cmd}),
        .q(pin_q)
    );
    assign {s_en, s_lock, s_win, s_boot, s_o114, s_o2v, s_cl, s_sw,
            s_ssd, s_slp, s_code, s_hi, s_lo} = pin_q;

    ////////////////////////////////////////////////////////////////////
    // State and registers
    cgps_state_t state_ff, nxt_state;
    cgps_fault_t fault_ff, nxt_fault;
    logic sw_prev_ff, slp_prev_ff, blank_ff, ctrl_off_ff;
    logic [CODE_W-1:0] code_prev_ff;
    logic [NEV-1:0] irq_st_ff, irq_mask_ff, nxt_irq_st, ev;
    logic core_good_oe_ff, delayed_good_oe_ff, high_side_gate_ff;
    logic low_side_gate_ff, ss_low_oe_ff, ss_high_ff, ref_code_ff;
    logic irq_ff, pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic nxt_cg, nxt_dg, nxt_hs, nxt_ls, nxt_ssl, nxt_ssh;
    logic tick, run_ok, armed, chg, dg_ready, ov_hit, cl_hit, fault_hit;
    logic in_run, latch_cl, nxt_blank;

    cgps_cnt_if boot_if ();
    cgps_cnt_if dly_if ();
    cgps_cnt_if dgc_if ();
    cgps_cnt_if blk_if ();
    cgps_cnt_if clc_if ();
    cgps_cnt_if saw_if ();

    // One switching cycle per rising edge of the modulator clock
    assign tick = s_sw && !sw_prev_ff;
    assign run_ok = s_en && !s_lock && !ctrl_off_ff;
    assign in_run = (state_ff == ST_RUN);
    assign latch_cl = (state_ff == ST_LATCH) && (fault_ff == FK_CL);
    // Code change seen only in run, so boot ignores the code pins
    assign chg = in_run && ((s_code != code_prev_ff) ||
                            (s_slp != slp_prev_ff));
    assign dg_ready = dgc_if.done && dly_if.done;

    ////////////////////////////////////////////////////////////////////
    // Counter hookup
    // boot hold timer
    assign boot_if.clear = (state_ff != ST_HOLD);
    assign boot_if.step = 1'b1;
    assign boot_if.target = CW'(BOOT_CYC);
    // minimum delay after core_good_n, cleared outside run
    assign dly_if.clear = !in_run;
    assign dly_if.step = 1'b1;
    assign dly_if.target = CW'(DELAY_CYCLES);
    assign dgc_if.clear = !in_run;
    assign dgc_if.step = tick;
    assign dgc_if.target = CW'(DG_TICKS);
    // blanking window restarts on every change
    assign blk_if.clear = chg;
    assign blk_if.step = tick;
    assign blk_if.target = CW'(BLANK_TICKS);
    // consecutive current-limited cycles, any clean cycle restarts
    assign clc_if.clear = !armed || (tick && !s_cl);
    assign clc_if.step = tick && s_cl;
    assign clc_if.target = CW'(CL_PULSES);
    // Sawtooth period on the soft-start pin after a current-limit latch
    assign saw_if.clear = !latch_cl || saw_if.done;
    assign saw_if.step = tick;
    assign saw_if.target = CW'(SAW_TICKS);

    cgps_counter u_boot (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(boot_if));
    cgps_counter u_dly (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(dly_if));
    cgps_counter u_dgc (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(dgc_if));
    cgps_counter u_blk (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(blk_if));
    cgps_counter u_clc (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(clc_if));
    cgps_counter u_saw (.clk_sys(clk_sys), .reset(reset), .ce(ce),
        .cnt(saw_if));

    ////////////////////////////////////////////////////////////////////
    // Fault detection
    // arm only after soft-start while delayed_good is low
    assign armed = in_run && s_ssd && delayed_good_oe_ff;
    // 114% trip armed and not blanked; 2.0V trip at any time
    assign ov_hit = (armed && !blank_ff && s_o114) || s_o2v;
    assign cl_hit = armed && clc_if.done;
    assign fault_hit = ov_hit || cl_hit;
    // Change sets blanking, the set wins over the end of the window
    assign nxt_blank = chg || (blank_ff && !blk_if.done);

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            // ramp to the boot level first
            ST_OFF: if (run_ok) nxt_state = ST_RAMP;
            ST_RAMP: if (s_boot) nxt_state = ST_HOLD;
            ST_HOLD: begin
                if (!s_boot) begin
                    nxt_state = ST_RAMP;
                end else if (boot_if.done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: nxt_state = ST_RUN;
            // latch holds while enable and supply stay good and ctrl_off_ff is clear
            ST_LATCH: nxt_state = ST_LATCH;
            default: nxt_state = ST_OFF;
        endcase
        if (fault_hit && state_ff != ST_OFF) begin
            nxt_state = ST_LATCH;
        end
        // lockout or disable restarts from the boot ramp
        if (!run_ok) begin
            nxt_state = ST_OFF;
        end
    end

    // Fault kind recorded on entry to the latch
    assign nxt_fault = (nxt_state == ST_OFF) ? FK_NONE :
        (state_ff != ST_LATCH && nxt_state == ST_LATCH) ?
        (ov_hit ? FK_OV : FK_CL) : fault_ff;

    ////////////////////////////////////////////////////////////////////
    // Output decode
    // Every decode also looks at run_ok, so lockout or disable wins in the
    // very cycle it is seen, not one cycle later when the state drops
    // pull low in run when in window or blanking
    assign nxt_cg = run_ok && in_run && (s_win || blank_ff);
    // release only once both delays are done
    assign nxt_dg = !(run_ok && in_run && dg_ready && (s_win || blank_ff));
    assign nxt_hs = run_ok && (state_ff != ST_OFF) && (state_ff != ST_LATCH)
        && s_hi;
    // over-voltage latch holds the low gate on
    assign nxt_ls = (!run_ok || state_ff == ST_OFF) ? 1'b0 :
        (state_ff == ST_LATCH && fault_ff == FK_OV) ? 1'b1 :
        s_lo && !(state_ff == ST_LATCH);
    // pull soft-start low in lockout, pulse it as a sawtooth
    assign nxt_ssl = !run_ok || (state_ff == ST_OFF) ||
        (latch_cl && saw_if.done);
    assign nxt_ssh = run_ok && (state_ff == ST_LATCH) && (fault_ff == FK_OV);

    // Interrupt events
    assign ev[EV_CG] = (state_ff == ST_HOLD) && (nxt_state == ST_RUN);
    assign ev[EV_DG] = delayed_good_oe_ff && !nxt_dg;
    assign ev[EV_FAULT] = (state_ff != ST_LATCH) && (nxt_state == ST_LATCH);
    assign ev[EV_LOCK] = s_lock && (state_ff != ST_OFF);

    ////////////////////////////////////////////////////////////////////
    // APB slave decode, one wait state, answer registered
    logic acc, fin, hit, wr_ctrl, wr_ist, wr_mask;
    logic [31:0] rd_mux, status_w;

    assign acc = psel && penable && !pready_ff;
    assign fin = psel && penable && pready_ff;
    assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                 (paddr == ADDR_IRQ_ST) || (paddr == ADDR_IRQ_MASK);
    assign wr_ctrl = fin && pwrite && (paddr == ADDR_CTRL);
    assign wr_ist = fin && pwrite && (paddr == ADDR_IRQ_ST);
    assign wr_mask = fin && pwrite && (paddr == ADDR_IRQ_MASK);
    assign status_w = 32'({3'(fault_ff), 3'(state_ff), blank_ff,
                           !delayed_good_oe_ff, core_good_oe_ff});
    assign rd_mux = (paddr == ADDR_CTRL) ? 32'(ctrl_off_ff) :
        (paddr == ADDR_STATUS) ? status_w :
        (paddr == ADDR_IRQ_ST) ? 32'(irq_st_ff) :
        (paddr == ADDR_IRQ_MASK) ? 32'(irq_mask_ff) : 32'h0;

    // Sticky status per event, a new event beats a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_irq
            assign nxt_irq_st[gi] = ev[gi] ||
                (irq_st_ff[gi] && !(wr_ist && pwdata[gi]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Sequencer registers; clock enable freezes everything
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ST_OFF;
            fault_ff <= FK_NONE;
            blank_ff <= 1'b0;
            sw_prev_ff <= 1'b0;
            slp_prev_ff <= 1'b0;
            code_prev_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
            fault_ff <= nxt_fault;
            blank_ff <= nxt_blank;
            sw_prev_ff <= s_sw;
            slp_prev_ff <= s_slp;
            code_prev_ff <= s_code;
        end
    end

    // Pin outputs; open-drain enables start released except delayed and soft-start low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            core_good_oe_ff <= 1'b0;
            delayed_good_oe_ff <= 1'b1;
            high_side_gate_ff <= 1'b0;
            low_side_gate_ff <= 1'b0;
            ss_low_oe_ff <= 1'b1;
            ss_high_ff <= 1'b0;
            ref_code_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            core_good_oe_ff <= nxt_cg;
            delayed_good_oe_ff <= nxt_dg;
            high_side_gate_ff <= nxt_hs;
            low_side_gate_ff <= nxt_ls;
            ss_low_oe_ff <= nxt_ssl;
            ss_high_ff <= nxt_ssh;
            // follow the code in run and in the fault latch
            ref_code_ff <= (nxt_state == ST_RUN) ||
                           (nxt_state == ST_LATCH);
            irq_ff <= |(nxt_irq_st & irq_mask_ff);
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_off_ff <= 1'b0;
            irq_st_ff <= '0;
            irq_mask_ff <= MASK_RST;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (ce) begin
            if (wr_ctrl) ctrl_off_ff <= pwdata[0];
            if (wr_mask) irq_mask_ff <= pwdata[NEV-1:0];
            irq_st_ff <= nxt_irq_st;
            pready_ff <= acc;
            pslverr_ff <= acc && !hit;
            if (acc) prdata_ff <= rd_mux;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign core_good_oe = core_good_oe_ff;
    assign delayed_good_oe = delayed_good_oe_ff;
    assign high_side_gate = high_side_gate_ff;
    assign low_side_gate = low_side_gate_ff;
    assign softstart_low_oe = ss_low_oe_ff;
    assign softstart_high = ss_high_ff;
    assign ref_follow_code = ref_code_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////
    // Checks
    cg_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && !run_ok |=> !core_good_oe_ff)
        else $error("core good asserted while off");
    dg_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && !run_ok |=> delayed_good_oe_ff)
        else $error("delayed good released while off");
    cg_boot_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && state_ff != ST_RUN |=> !core_good_oe_ff)
        else $error("core good asserted before boot hold");
    cg_blank_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && run_ok && in_run && blank_ff |=> core_good_oe_ff)
        else $error("core good not forced during blanking");
    dg_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(delayed_good_oe_ff) |-> $past(dly_if.done && dgc_if.done))
        else $error("delayed good released before both delays");
    lock_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && !run_ok |=> !high_side_gate_ff && !low_side_gate_ff
        && ss_low_oe_ff)
        else $error("gates or soft-start wrong in lockout");
    ov_latch_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && run_ok && state_ff == ST_LATCH && fault_ff == FK_OV |=>
        low_side_gate_ff && ss_high_ff && !high_side_gate_ff)
        else $error("over-voltage latch outputs wrong");
    cl_latch_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && latch_cl |=> !high_side_gate_ff && !ss_high_ff)
        else $error("current-limit latch outputs wrong");
    latch_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && state_ff == ST_LATCH && run_ok |=> state_ff == ST_LATCH)
        else $error("latched fault released without cycling");
    ref_boot_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce && (state_ff == ST_RAMP) && !fault_hit |=> !ref_code_ff)
        else $error("reference follows code during boot ramp");
endmodule

//--- hdl/cgps_pkg.sv
// Constants and types shared by the core rail power-good sequencer
package cgps_pkg;
    // Clock and timing
    localparam int CLK_HZ = 25000000;
    localparam int US_PER_S = 1000000;
    localparam int MS_PER_S = 1000;
    localparam int BOOT_US = 10;
    localparam int BOOT_CYC = (BOOT_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
    localparam int DELAY_MS = 3;
    localparam int DELAY_CYC = DELAY_MS * (CLK_HZ / MS_PER_S);
    // Counts in switching cycles or pulses
    localparam int DG_TICKS = 1007;
    localparam int BLANK_TICKS = 62;
    localparam int CL_PULSES = 32;
    localparam int SAW_TICKS = 16;
    // Counter width, pin bundle width, code width
    localparam int CW = 17;
    localparam int CODE_W = 6;
    localparam int PIN_W = 18;
    // APB register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
    // Interrupt events
    localparam int NEV = 4;
    localparam int EV_CG = 0;
    localparam int EV_DG = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_LOCK = 3;
    localparam logic [NEV-1:0] MASK_RST = 4'h0;
    // Sequencer states and latched fault kinds
    typedef enum {ST_OFF, ST_RAMP, ST_HOLD, ST_RUN, ST_LATCH} cgps_state_t;
    typedef enum {FK_NONE, FK_CL, FK_OV} cgps_fault_t;
endpackage

//--- hdl/cgps_cnt_if.sv
// Control and status bundle between the sequencer and one counter
`timescale 1ns/1ns
interface cgps_cnt_if
    import cgps_pkg::*;
();
    logic clear;
    logic step;
    logic [CW-1:0] target;
    logic done;
    modport ctl (output clear, output step, output target, input done);
    modport cnt (input clear, input step, input target, output done);
endinterface

//--- hdl/cgps_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
module cgps_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    ////////////////////////////////////////////////////////////////////
    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

//--- hdl/cgps_counter.sv
// Saturating counter driven through the counter interface
`timescale 1ns/1ns
module cgps_counter
    import cgps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    cgps_cnt_if.cnt cnt
);
    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;

    ////////////////////////////////////////////////////////////////////
    // Clear wins over step; saturating keeps done up until cleared
    assign nxt_count = cnt.clear ? '0 :
        (cnt.step && !cnt.done) ? count_ff + 1'b1 : count_ff;
    assign cnt.done = (count_ff == cnt.target);

    // Count register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_ff <= '0;
        end else if (ce) begin
            count_ff <= nxt_count;
        end
    end
endmodule

//--- testbench/cgps_rail_model.sv
// Behavioural core rail: switching clock, boot level and window flags
`timescale 1ns/1ns
module cgps_rail_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic softstart_low_oe,
    input wire logic win_req,
    output logic switch_clk,
    output logic at_boot_level,
    output logic in_window
);
    logic [1:0] div_ff;
    logic [4:0] ramp_ff;
    ////////////////////////////////////////
    // One switching cycle every four clocks, slow enough for the synchroniser
    always_ff @(posedge clk_sys) begin
        div_ff <= reset ? 2'h0 : div_ff + 2'h1;
    end
    assign switch_clk = div_ff[1];
    // Rail climbs only once the soft-start cap is let go; a clamp restarts it
    always_ff @(posedge clk_sys) begin
        if (reset || softstart_low_oe) begin
            ramp_ff <= 5'h0;
        end else if (ramp_ff != 5'h1f) begin
            ramp_ff <= ramp_ff + 5'h1;
        end
    end
    assign at_boot_level = (ramp_ff == 5'h1f);
    // Window comparator means nothing below the boot level
    assign in_window = at_boot_level && win_req;
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the core rail power-good sequencer
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module testbench;
    import cgps_pkg::*;
    // Short delay keeps the run small; it is the longer of the two waits
    localparam int DLY = 6000;
    logic clk_sys, reset, ce, enable_pin, supply_lockout, in_window;
    logic at_boot_level, overvoltage_trip, over_2v_trip, cur_limit;
    logic switch_clk, softstart_done, sleep_pin, high_cmd, low_cmd, win_req;
    logic psel, penable, pwrite, pready, pslverr, core_good_oe, irq;
    logic delayed_good_oe, high_side_gate, low_side_gate, e;
    logic softstart_low_oe, softstart_high, ref_follow_code;
    logic [CODE_W-1:0] voltage_code;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int err_total = 0;
    int tests_run = 0;
    int sw_cnt = 0;
    int n, s0;
    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Count switching cycles seen by the device
    always @(posedge switch_clk) sw_cnt++;
    cgps_top #(.DELAY_CYCLES(DLY)) i_dut (.clk_sys(clk_sys), .reset(reset),
        .ce(ce), .enable_pin(enable_pin), .supply_lockout(supply_lockout),
        .in_window(in_window), .at_boot_level(at_boot_level),
        .overvoltage_trip(overvoltage_trip), .over_2v_trip(over_2v_trip),
        .cur_limit(cur_limit), .switch_clk(switch_clk),
        .softstart_done(softstart_done), .sleep_pin(sleep_pin),
        .voltage_code(voltage_code), .high_cmd(high_cmd), .low_cmd(low_cmd),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_good_oe(core_good_oe), .delayed_good_oe(delayed_good_oe),
        .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
        .softstart_low_oe(softstart_low_oe), .softstart_high(softstart_high),
        .ref_follow_code(ref_follow_code), .irq(irq));
    cgps_rail_model i_rail (.clk_sys(clk_sys), .reset(reset),
        .softstart_low_oe(softstart_low_oe), .win_req(win_req),
        .switch_clk(switch_clk), .at_boot_level(at_boot_level),
        .in_window(in_window));
    ////////////////////////////////////////
    // Verdict and end of run, also used when a wait runs out
    task summarize;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task hang(input string what);
        err_total++;
        $display("CHECK FAILED %s exp done got timeout", what);
        summarize();
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // One APB transfer; held until pready is sampled high
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && k < 16) begin
            @(posedge clk_sys);
            k++;
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) hang("apb");
    endtask
    // Bounded wait for a power-good level; n returns the cycles taken
    task wait_out(input logic dg, input logic v, input int lim);
        n = 0;
        while ((dg ? delayed_good_oe : core_good_oe) !== v) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) hang("power_good");
        end
    endtask
    ////////////////////////////////////////
    initial begin
        {reset, ce, enable_pin, supply_lockout, overvoltage_trip} = 5'h18;
        {over_2v_trip, cur_limit, softstart_done, sleep_pin} = 4'h0;
        {high_cmd, low_cmd, win_req, psel, penable, pwrite} = 6'h08;
        voltage_code = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(10);
        reset <= 1'b0;
        cyc(3);
        `CHECK("core_good_oe", 1'b0, core_good_oe)
        `CHECK("delayed_good_oe", 1'b1, delayed_good_oe)
        `CHECK("ss_low", 1'b1, softstart_low_oe)
        `CHECK("gates", 2'h0, {high_side_gate, low_side_gate})
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        `CHECK("irq_mask", {28'h0, MASK_RST}, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHECK("unmapped", 1'b1, e)
        apb(1'b1, ADDR_IRQ_MASK, 32'h3);
        $display("test reset done");
        // Start-up with an early 114% trip, which must not latch yet
        overvoltage_trip <= 1'b1;
        enable_pin <= 1'b1;
        cyc(100);
        voltage_code <= 6'h15;
        cyc(60);
        `CHECK("ref_boot", 1'b0, ref_follow_code)
        `CHECK("cg_hold", 1'b0, core_good_oe)
        wait_out(1'b0, 1'b1, 2000);
        `CHECK("boot_time", 1'b1, n + 160 >= BOOT_CYC + 31)
        cyc(2);
        `CHECK("ref_code", 1'b1, ref_follow_code)
        s0 = sw_cnt;
        overvoltage_trip <= 1'b0;
        softstart_done <= 1'b1;
        wait_out(1'b1, 1'b0, DLY + 500);
        `CHECK("dg_delay", 1'b1, n + 8 > DLY && n < DLY + 8)
        `CHECK("dg_ticks", 1'b1, sw_cnt - s0 >= DG_TICKS)
        cyc(3);
        `CHECK("irq_up", 1'b1, irq)
        apb(1'b0, ADDR_IRQ_ST, 32'h0);
        `CHECK("irq_st", 32'h3, rd)
        apb(1'b1, ADDR_IRQ_ST, 32'h3);
        cyc(3);
        `CHECK("irq_clr", 1'b0, irq)
        // Gate requests stay high from here, so later gate checks mean much
        {high_cmd, low_cmd} <= 2'h3;
        cyc(4);
        `CHECK("gates_run", 2'h3, {high_side_gate, low_side_gate})
        $display("test startup done");
        // Leave the window, then change the code and sleep
        win_req <= 1'b0;
        cyc(8);
        `CHECK("cg_out", 1'b0, core_good_oe)
        `CHECK("dg_out", 1'b1, delayed_good_oe)
        voltage_code <= 6'h2a;
        cyc(8);
        `CHECK("cg_blank", 1'b1, core_good_oe)
        `CHECK("dg_blank", 1'b0, delayed_good_oe)
        cyc(200);
        `CHECK("blank_52", 1'b1, core_good_oe)
        cyc(60);
        `CHECK("blank_67", 1'b0, core_good_oe)
        sleep_pin <= 1'b1;
        cyc(8);
        `CHECK("cg_sleep", 1'b1, core_good_oe)
        cyc(300);
        $display("test blanking done");
        // Current limit: a 25-cycle burst, a gap, then a sustained run
        apb(1'b1, ADDR_IRQ_MASK, 32'h4);
        cur_limit <= 1'b1;
        cyc(100);
        cur_limit <= 1'b0;
        cyc(20);
        cur_limit <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHECK("cl_short", 3'h3, rd[5:3])
        cyc(200);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHECK("cl_latch", 6'h0c, rd[8:3])
        `CHECK("cl_high", 1'b0, high_side_gate)
        `CHECK("cl_irq", 1'b1, irq)
        s0 = 0;
        repeat (128) begin
            @(posedge clk_sys);
            s0 += (softstart_low_oe === 1'b1);
        end
        `CHECK("sawtooth", 2, s0)
        cur_limit <= 1'b0;
        cyc(50);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHECK("cl_held", 3'h4, rd[5:3])
        enable_pin <= 1'b0;
        cyc(6);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHECK("off_state", 3'h0, rd[5:3])
        `CHECK("off_dg", 1'b1, delayed_good_oe)
        $display("test current limit done");
        // 2.0V trip during the ramp, cleared by supply lockout
        enable_pin <= 1'b1;
        over_2v_trip <= 1'b1;
        cyc(20);
        `CHECK("ov_pins", 3'h5, {low_side_gate, high_side_gate,
            softstart_high})
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHECK("ov_latch", 6'h14, rd[8:3])
        ce <= 1'b0;
        supply_lockout <= 1'b1;
        win_req <= 1'b1;
        cyc(6);
        `CHECK("ce_freeze", 1'b1, softstart_high)
        ce <= 1'b1;
        cyc(6);
        `CHECK("lock_gates", 2'h0, {high_side_gate, low_side_gate})
        `CHECK("lock_ss", 1'b1, softstart_low_oe)
        `CHECK("lock_cg", 1'b0, core_good_oe)
        `CHECK("lock_dg", 1'b1, delayed_good_oe)
        over_2v_trip <= 1'b0;
        supply_lockout <= 1'b0;
        wait_out(1'b0, 1'b1, 2000);
        `CHECK("restart", 1'b1, n >= BOOT_CYC + 31)
        $display("test faults done");
        summarize();
    end
endmodule
